// ==== rtl/chop_timing_if.sv ====
`timescale 1ns/1ps
// Purpose: Carries oscillator timing from the divider to the controller
// Assumes: Single clock domain
// Notes:   All members are registered in the divider
interface chop_timing_if;
   logic       osc_tick;
   logic       period_start;
   logic [2:0] chop_phase;

   modport src (output osc_tick, output period_start, output chop_phase);
   modport snk (input osc_tick, input period_start, input chop_phase);
endinterface

// ==== rtl/chopper_pkg.sv ====
// Purpose: Shared constants and types for the chopper decay control
// Assumes: System clock of 125 MHz drives every register
// Notes:   The reference oscillator is derived from the system clock
package chopper_pkg;

   // ************************************************************
   // Clock and reference oscillator
   // ************************************************************
   localparam int CLK_KHZ     = 125000;
   localparam int OSC_KHZ     = 800;
   localparam int OSC_MAX_KHZ = 1000;
   // Divider rounds up so the oscillator never runs above nominal
   localparam int OSC_DIV     = (CLK_KHZ + OSC_KHZ - 1) / OSC_KHZ;
   localparam logic [7:0] OSC_DIV_LAST = 8'(OSC_DIV - 1);
   localparam logic [7:0] OSC_CNT_RST  = 8'h00;

   // ************************************************************
   // Chopping period
   // ************************************************************
   localparam int CHOP_DIV = 8;
   localparam logic [2:0] CHOP_LAST   = 3'(CHOP_DIV - 1);
   localparam logic [2:0] CHOP_FIRST  = 3'h0;
   localparam int MIX_PER_MILLE = 375;
   localparam logic [2:0] DECAY_SWITCH_PHASE =
      3'(CHOP_DIV - (CHOP_DIV * MIX_PER_MILLE) / 1000);
   localparam logic [2:0] DC_CHARGE_TICKS = 3'h3;
   localparam logic [2:0] BLANK_TICKS     = 3'h4;
   localparam logic [2:0] OC_CONFIRM_LAST = 3'h5;
   localparam logic [2:0] CNT3_RST        = 3'h0;

   // ************************************************************
   // Synchronised input slots
   // ************************************************************
   localparam int IN_NUM = 6;
   localparam int IN_EN  = 0;
   localparam int IN_DIR = 1;
   localparam int IN_DC  = 2;
   localparam int IN_RCH = 3;
   localparam int IN_OC  = 4;
   localparam int IN_TH  = 5;
   localparam logic [5:0] IN_RST = 6'h00;

   // Gate order: u1, u2, l1, l2
   localparam logic [3:0] GATE_OFF    = 4'h0;
   localparam logic [3:0] GATE_SLOW   = 4'h3;
   localparam logic [3:0] GATE_CHG_FW = 4'h9;
   localparam logic [3:0] GATE_FST_FW = 4'h6;
   localparam logic [3:0] GATE_CHG_RV = 4'h6;
   localparam logic [3:0] GATE_FST_RV = 4'h9;

   typedef enum logic [1:0] {
      MODE_CHARGE,
      MODE_SLOW,
      MODE_FAST
   } decay_mode_t;

endpackage

// ==== rtl/motor_chopper_decay_control.sv ====
`timescale 1ns/1ps
// Purpose: Constant-current chopper sequencing for one H-bridge
// Assumes: reset_n_i is the power-on reset; all pins are asynchronous
// Notes:   Gate outputs high switch a transistor on; all low is Hi-Z
//
// Function
// - Thermal flag turns every bridge transistor off
// - Thermal halt holds until power-on reset
// - Over-current turns every gate output off via halt
// - Over-current halt latched until power-on reset
// - Decay switch point at 62.5% of period
// - Late current-reached goes charge straight to fast
// - Chopping period is oscillator divided by eight
// - Reference oscillator near 800 kHz, max 1000
// - Each period starts in charge, then steps slow, then fast if current is reached early
// - Over-current ignored four oscillator cycles after switching
// - Over-current stops outputs within five to eight cycles only while charge stands, current never reached
// - Brushed DC charges first three cycles, blanking
module motor_chopper_decay_control (
   input  wire logic clk_sys_i,
   input  wire logic reset_n_i,
   input  wire logic enable_i,
   input  wire logic direction_i,
   input  wire logic dc_mode_i,
   input  wire logic set_current_reached_i,
   input  wire logic overcurrent_i,
   input  wire logic thermal_flag_i,
   output logic      gate_u1_o,
   output logic      gate_u2_o,
   output logic      gate_l1_o,
   output logic      gate_l2_o,
   output logic      thermal_halt_o,
   output logic      overcurrent_halt_o
);

   typedef struct packed {
      logic [5:0]                sync1;
      logic [5:0]                sync2;
      logic [5:0]                sync3;
      logic [5:0]                pin;
      chopper_pkg::decay_mode_t  mode;
      logic [2:0]                blank_cnt;
      logic [2:0]                oc_cnt;
      logic                      overcurrent_halt;
      logic                      thermal_halt;
      logic [3:0]                gates;
   } ctl_state_t;

   ctl_state_t s_q;
   ctl_state_t s_d;
   logic [5:0] pins_raw;
   logic [5:0] pin_agreed;
   logic       forward;
   logic       oc_armed;
   logic       oc_confirmed;

   // ************************************************************
   // Reference oscillator
   // ************************************************************
   chop_timing_if tim ();

   ref_osc_divider u_osc (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .tim       (tim)
   );

   // ************************************************************
   // Input capture
   // ************************************************************
   assign pins_raw = {thermal_flag_i, overcurrent_i,
                      set_current_reached_i, dc_mode_i,
                      direction_i, enable_i};

   // Stages two and three must agree, so one metastable sample
   // never moves a pin
   for (genvar i = 0; i < chopper_pkg::IN_NUM; i = i + 1) begin : g_agree
      assign pin_agreed[i] = (s_q.sync2[i] == s_q.sync3[i]) ?
                             s_q.sync3[i] : s_q.pin[i];
   end

   // ************************************************************
   // Decoded conditions
   // ************************************************************
   assign forward      = s_q.pin[chopper_pkg::IN_DIR];
   // Blanked after every switch to skip recovery spikes
   assign oc_armed     = s_q.pin[chopper_pkg::IN_OC] &&
                         s_q.blank_cnt == chopper_pkg::CNT3_RST;
   // Six unblanked ticks in a row keep the stop inside 5 to 8
   assign oc_confirmed = oc_armed &&
                         s_q.oc_cnt == chopper_pkg::OC_CONFIRM_LAST;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      s_d = s_q;

      // Three-stage capture, accepted once stages two and three agree
      s_d.sync1 = pins_raw;
      s_d.sync2 = s_q.sync1;
      s_d.sync3 = s_q.sync2;
      s_d.pin   = pin_agreed;

      // ************************************************************
      // Oscillator tick work
      // ************************************************************
      if (tim.osc_tick) begin
         if (s_q.blank_cnt != chopper_pkg::CNT3_RST) begin
            s_d.blank_cnt = s_q.blank_cnt - 3'h1;
         end

         if (tim.period_start) begin
            s_d.mode = chopper_pkg::MODE_CHARGE;
         end else begin
            case (s_q.mode)
               chopper_pkg::MODE_CHARGE: begin
                  // DC mode holds charge as digital blanking
                  if (s_q.pin[chopper_pkg::IN_DC] &&
                      tim.chop_phase < chopper_pkg::DC_CHARGE_TICKS) begin
                     s_d.mode = chopper_pkg::MODE_CHARGE;
                  end else if (s_q.pin[chopper_pkg::IN_RCH]) begin
                     if (tim.chop_phase <
                         chopper_pkg::DECAY_SWITCH_PHASE) begin
                        s_d.mode = chopper_pkg::MODE_SLOW;
                     end else begin
                        s_d.mode = chopper_pkg::MODE_FAST;
                     end
                  end
               end
               chopper_pkg::MODE_SLOW: begin
                  if (tim.chop_phase >= chopper_pkg::DECAY_SWITCH_PHASE) begin
                     s_d.mode = chopper_pkg::MODE_FAST;
                  end
               end
               default: begin
                  s_d.mode = chopper_pkg::MODE_FAST;
               end
            endcase
         end

         // Switching restarts the dead band
         if (s_d.mode != s_q.mode) begin
            s_d.blank_cnt = chopper_pkg::BLANK_TICKS;
         end

         // Sampled on oscillator ticks only, so halting is synchronous
         // to the oscillator
         if (oc_armed) begin
            if (oc_confirmed) begin
               s_d.overcurrent_halt = 1'b1;
            end else begin
               s_d.oc_cnt = s_q.oc_cnt + 3'h1;
            end
         end else begin
            s_d.oc_cnt = chopper_pkg::CNT3_RST;
         end
      end

      // ************************************************************
      // Halt latches
      // ************************************************************
      // Thermal acts on the system clock, with no tick wait
      // Sticky: only the power-on reset clears either halt
      if (s_q.pin[chopper_pkg::IN_TH]) begin
         s_d.thermal_halt = 1'b1;
      end

      // ************************************************************
      // Gate drive
      // ************************************************************
      // Common halt path forces all transistors off
      // Enable low is not latched: drive resumes with it
      if (s_d.thermal_halt || s_d.overcurrent_halt ||
          !s_q.pin[chopper_pkg::IN_EN]) begin
         s_d.gates = chopper_pkg::GATE_OFF;
      end else begin
         case (s_d.mode)
            chopper_pkg::MODE_CHARGE: begin
               if (forward) begin
                  s_d.gates = chopper_pkg::GATE_CHG_FW;
               end else begin
                  s_d.gates = chopper_pkg::GATE_CHG_RV;
               end
            end
            chopper_pkg::MODE_SLOW: begin
               s_d.gates = chopper_pkg::GATE_SLOW;
            end
            default: begin
               if (forward) begin
                  s_d.gates = chopper_pkg::GATE_FST_FW;
               end else begin
                  s_d.gates = chopper_pkg::GATE_FST_RV;
               end
            end
         endcase
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign gate_u1_o          = s_q.gates[3];
   assign gate_u2_o          = s_q.gates[2];
   assign gate_l1_o          = s_q.gates[1];
   assign gate_l2_o          = s_q.gates[0];
   assign thermal_halt_o     = s_q.thermal_halt;
   assign overcurrent_halt_o = s_q.overcurrent_halt;

endmodule

// ==== rtl/ref_osc_divider.sv ====
`timescale 1ns/1ps
// Purpose: Reference oscillator tick and chopping phase counter
// Assumes: clk_sys_i at 125 MHz
// Notes:   Tick is one system cycle wide, once per oscillator cycle
module ref_osc_divider (
   input  wire logic clk_sys_i,
   input  wire logic reset_n_i,
   chop_timing_if.src tim
);

   typedef struct packed {
      logic [7:0] div_cnt;
      logic [2:0] phase;
      logic       tick;
      logic       start;
   } osc_state_t;

   osc_state_t s_q;
   osc_state_t s_d;

   // ************************************************************
   // Divider
   // ************************************************************
   always_comb begin
      s_d       = s_q;
      s_d.tick  = 1'b0;
      s_d.start = 1'b0;
      if (s_q.div_cnt == chopper_pkg::OSC_DIV_LAST) begin
         // Near 800 kHz, never above the 1000 kHz ceiling
         s_d.div_cnt = chopper_pkg::OSC_CNT_RST;
         s_d.tick    = 1'b1;
         // Chopping period is eight oscillator cycles
         if (s_q.phase == chopper_pkg::CHOP_LAST) begin
            s_d.phase = chopper_pkg::CHOP_FIRST;
            s_d.start = 1'b1;
         end else begin
            s_d.phase = s_q.phase + 3'h1;
         end
      end else begin
         s_d.div_cnt = s_q.div_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tim.osc_tick     = s_q.tick;
   assign tim.period_start = s_q.start;
   assign tim.chop_phase   = s_q.phase;

endmodule

// ==== tb/coil_model.sv ====
// Purpose: Coil current and fault source facing the chopper
// Assumes: One clock; current rises in charge, holds in slow decay, falls otherwise
// Notes:   Faults appear only when the bench asks for them
`timescale 1ns/1ps
module coil_model (
   input  wire logic        clk_sys_i,
   input  wire logic        dir_i,
   input  wire logic [3:0]  gates_i,
   input  wire logic [15:0] thr_i,
   input  wire logic        th_req_i,
   input  wire logic        oc_req_i,
   output logic             reached_o,
   output logic             oc_o,
   output logic             th_o
);
   // ************************************************************
   // Current level
   // ************************************************************
   int lvl = 0;
   wire [3:0] chg = dir_i ? chopper_pkg::GATE_CHG_FW
                          : chopper_pkg::GATE_CHG_RV;
   // Slow decay holds the level; crude but keeps periods apart
   always @(posedge clk_sys_i) begin
      if (gates_i == chg)
         lvl <= lvl + 1;
      else if (gates_i != chopper_pkg::GATE_SLOW)
         lvl <= (lvl > 16) ? lvl - 16 : 0;
   end
   assign reached_o = (lvl >= int'(thr_i));
   assign oc_o = oc_req_i;
   assign th_o = th_req_i;
endmodule

// ==== tb/motor_chopper_decay_control_bench.sv ====
// Purpose: Self-checking bench for the chopper decay control
// Assumes: Oscillator tick every 157 clocks, eight ticks a period
// Notes:   Every run starts with a reset and ends in a latched halt
`timescale 1ns/1ps
module motor_chopper_decay_control_bench;
   // ************************************************************
   // Stimulus and checking
   // ************************************************************
   localparam int TICK = 157;
   localparam int PER  = 8 * TICK;
   logic        clk_sys_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        en = 1'b0, dir = 1'b0, dc = 1'b0;
   logic        th_req = 1'b0, oc_req = 1'b0;
   logic [15:0] thr = 16'hFFFF;
   logic [16:0] rnd = 17'h18021;
   logic        reached, oc, th, u1, u2, l1, l2, thh, och;
   logic        thh_q = 1'b0, och_q = 1'b0;
   logic [1:0]  exp_q[$];
   int          fail_count = 0, cmp_count = 0;
   int          slow_cnt = 0, fast_cnt = 0, n, m;
   wire [3:0]   gates = {u1, u2, l1, l2};
   wire [3:0]   fst = dir ? chopper_pkg::GATE_FST_FW
                          : chopper_pkg::GATE_FST_RV;
   always #4 clk_sys_i = ~clk_sys_i;
   motor_chopper_decay_control dut (.clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i), .enable_i(en), .direction_i(dir),
      .dc_mode_i(dc), .set_current_reached_i(reached), .overcurrent_i(oc),
      .thermal_flag_i(th), .gate_u1_o(u1), .gate_u2_o(u2),
      .gate_l1_o(l1), .gate_l2_o(l2), .thermal_halt_o(thh),
      .overcurrent_halt_o(och));
   coil_model coil (.clk_sys_i(clk_sys_i), .dir_i(dir), .gates_i(gates),
      .thr_i(thr), .th_req_i(th_req), .oc_req_i(oc_req), .reached_o(reached),
      .oc_o(oc), .th_o(th));
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   task automatic chk_halt(input logic [1:0] e, input logic [1:0] s);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED halt expected %h seen %h", e, s);
      end
   endtask
   task automatic chk_val(input string w, input logic [3:0] e,
                          input logic [3:0] s);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic end_of_test;
      if (fail_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Halt rises are matched against the oldest expected halt
   always @(posedge clk_sys_i) begin
      thh_q <= thh;
      och_q <= och;
      if (gates == chopper_pkg::GATE_SLOW) slow_cnt++;
      if (gates == fst) fast_cnt++;
      if ((thh && !thh_q) || (och && !och_q)) begin
         if (exp_q.size() > 0) chk_halt(exp_q.pop_front(), {och, thh});
         else chk_halt(2'h0, {och, thh});
      end
   end
   initial begin
      repeat (70000) @(posedge clk_sys_i);
      fail_count++;
      end_of_test();
   end
   initial begin
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys_i);
         rnd = lfsr(rnd);
         reset_n_i <= 1'b0;
         dc <= i[0];
         dir <= i[1];
         en <= 1'b1;
         thr <= 16'(rnd[7:0]) + 16'h0040;
         repeat (2) @(posedge clk_sys_i);
         reset_n_i <= 1'b1;
         n = slow_cnt;
         repeat (2 * PER) @(posedge clk_sys_i);
         chk_val("slow seen", 4'h1, 4'(slow_cnt != n));
         en <= 1'b0;
         repeat (12) @(posedge clk_sys_i);
         chk_val("disabled gates", 4'h0, gates);
         en <= 1'b1;
         // Capped so the level is reached before the last tick
         thr <= 16'(rnd[15:9]) + 16'h0384;
         repeat (PER) @(posedge clk_sys_i);
         n = slow_cnt;
         m = fast_cnt;
         repeat (2 * PER) @(posedge clk_sys_i);
         chk_val("late slow", 4'h0, 4'(slow_cnt != n));
         chk_val("late fast", 4'h1, 4'(fast_cnt != m));
         // Never reached: charge stands, so nothing re-arms blanking
         thr <= 16'hFFFF;
         repeat (2 * PER) @(posedge clk_sys_i);
         if (i < 2) begin
            exp_q.push_back(2'h1);
            th_req <= 1'b1;
            repeat (20) @(posedge clk_sys_i);
            th_req <= 1'b0;
         end else begin
            exp_q.push_back(2'h2);
            oc_req <= 1'b1;
            n = 0;
            while (!och && n < 1400) begin
               @(posedge clk_sys_i);
               n++;
            end
            chk_val("oc delay", 4'h1, 4'(n >= 5 * TICK && n <= PER + 8));
            oc_req <= 1'b0;
         end
         repeat (2 * PER) @(posedge clk_sys_i);
         chk_val("halted gates", 4'h0, gates);
      end
      end_of_test();
   end
endmodule

// ==== tb/motor_chopper_decay_control_monitor.sv ====
// Purpose: Port-level checks of halts and decay sequencing
// Assumes: Direction and mode change only while reset is held
// Notes:   Bound into the top module
`timescale 1ns/1ps
module chopper_monitor (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic direction_i,
   input wire logic dc_mode_i,
   input wire logic thermal_flag_i,
   input wire logic gate_u1_o,
   input wire logic gate_u2_o,
   input wire logic gate_l1_o,
   input wire logic gate_l2_o,
   input wire logic thermal_halt_o,
   input wire logic overcurrent_halt_o
);
   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   wire [3:0] g = {gate_u1_o, gate_u2_o, gate_l1_o, gate_l2_o};
   wire [3:0] fst = direction_i ? chopper_pkg::GATE_FST_FW
                                : chopper_pkg::GATE_FST_RV;
   wire [3:0] chg = direction_i ? chopper_pkg::GATE_CHG_FW
                                : chopper_pkg::GATE_CHG_RV;
   localparam int PER_LEN = chopper_pkg::CHOP_DIV * chopper_pkg::OSC_DIV;
   localparam int DC_MIN = 3 * chopper_pkg::OSC_DIV;
   localparam int SWITCH_LEN = PER_LEN - PER_LEN * 375 / 1000;
   localparam int PER_MIN = 8 * chopper_pkg::CLK_KHZ / 1000;
   // Cycles since the last fast-to-charge edge, the period start
   logic [3:0]  g_q;
   logic [10:0] run_len;
   logic        run_full;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         g_q      <= 4'h0;
         run_len  <= 11'h000;
         run_full <= 1'b0;
      end else begin
         g_q <= g;
         if (g == chg && g_q == fst) begin
            run_len  <= 11'h001;
            run_full <= 1'b1;
         end else if (g == 4'h0) begin
            run_full <= 1'b0;
         end else if (run_len != 11'h7FF) begin
            run_len <= run_len + 11'h001;
         end
      end
   end
   dc_charge_a: assert property (
      (dc_mode_i && run_full && g_q == chg && g != chg && g != 4'h0)
      |-> run_len >= 11'(DC_MIN)) else $error("DC charge left early");
   switch_point_a: assert property (
      (run_full && g_q == 4'h3 && g == fst) |-> run_len == 11'(SWITCH_LEN))
      else $error("decay switch point off");
   period_len_a: assert property (
      (run_full && g_q == fst && g == chg)
      |-> run_len == 11'(PER_LEN) && run_len >= 11'(PER_MIN))
      else $error("chopping period wrong");
   thermal_off_a: assert property (
      thermal_halt_o |-> g == 4'h0) else $error("gates on in halt");
   thermal_fast_a: assert property (
      $rose(thermal_flag_i) |-> ##[1:8] thermal_halt_o)
      else $error("thermal halt late");
   thermal_hold_a: assert property (
      thermal_halt_o |=> thermal_halt_o) else $error("thermal dropped");
   oc_off_a: assert property (
      overcurrent_halt_o |-> g == 4'h0) else $error("gates on in halt");
   oc_hold_a: assert property (
      overcurrent_halt_o |=> overcurrent_halt_o)
      else $error("overcurrent halt dropped");
   halt_clear_a: assert property (
      $rose(reset_n_i) |-> !thermal_halt_o && !overcurrent_halt_o)
      else $error("halt set after reset");
   gate_legal_a: assert property (
      g inside {4'h0, 4'h3, 4'h6, 4'h9}) else $error("bad gate code");
   slow_next_a: assert property (
      ($past(g) == 4'h3 && g != 4'h3) |-> (g == fst || g == 4'h0))
      else $error("slow not followed by fast");
   fast_next_a: assert property (
      ($past(g) == fst && g != fst) |-> (g == chg || g == 4'h0))
      else $error("fast not followed by charge");
endmodule
bind motor_chopper_decay_control chopper_monitor mon (.clk_sys_i,
   .reset_n_i, .direction_i, .dc_mode_i, .thermal_flag_i, .gate_u1_o,
   .gate_u2_o, .gate_l1_o, .gate_l2_o, .thermal_halt_o, .overcurrent_halt_o);
